// ==== rtl/iisd_datapath.sv ====
// Transmit datapath: FIFO, half-band x2 interpolator, inverse sinc, gain and offset.
// Assumes i_clk is the converter sample clock and all inputs are synchronous to it;
// the converter core accepts one sample per cycle.
//
// Operation
// - Stages run in order: half-band, inverse sinc, gain and offset.
// - Interpolation on doubles output rate and low-pass filters the image.
// - Only two modes: pass-through or interpolate by two.
// - Half-band is symmetric 55-tap filter, centre 32768, printed odd taps.
// - Inverse sinc is a seven-tap FIR at the update rate.
// - Inverse sinc taps are -1, 4, -16, 192 symmetric.
// - Inverse sinc bypassed after reset; enable bit turns it on.
// - Enabled inverse sinc costs roughly 3.8 dB insertion loss.
// - Latency is fixed: each stage keeps its register whether enabled or bypassed.
// - Interpolation mode chosen by the mode select input.
`timescale 1ns/1ps
`include "iisd_defines.svh"
module iisd_datapath
  import iisd_pkg::*;
#(
  parameter int SW    = `IISD_SAMPLE_W,
  parameter int DEPTH = `IISD_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_n,
  // Upstream samples
  input  wire logic                 i_in_valid,
  input  wire logic signed [SW-1:0] i_in_data,
  output logic                      o_in_ready,
  // Configuration levels
  input  wire logic                 i_interp_x2,
  input  wire logic                 i_inverse_sinc_enable,
  input  wire logic [15:0]          i_gain,
  input  wire logic signed [SW-1:0] i_offset,
  // Converter core samples
  output logic                      o_out_valid,
  output logic signed [SW-1:0]      o_out_data
);
  localparam int HBN = `IISD_HB_TAPS;
  localparam int AW  = 48;
  localparam logic signed [SW-1:0] SMAX = {1'b0, {(SW-1){1'b1}}};
  localparam logic signed [SW-1:0] SMIN = {1'b1, {(SW-1){1'b0}}};
  // Odd-tap magnitudes of the half-band, outermost first (taps 1..27)
  localparam int HB_C [14] = '{-4, 13, -32, 69, -134, 239, -401, 642,
                               -994, 1512, -2307, 3665, -6638, 20754};

  // Round off SH bits and saturate to the sample width
  function automatic logic signed [SW-1:0] rnd_sat(input logic signed [AW-1:0] acc, input int sh);
    logic signed [AW-1:0] r;
    r = (acc + (48'sd1 <<< (sh - 1))) >>> sh;
    if (r > AW'(SMAX))
      rnd_sat = SMAX;
    // Signed compare; a plain concatenation would be unsigned and clip small positives
    else if (r < AW'(SMIN))
      rnd_sat = SMIN;
    else
      rnd_sat = r[SW-1:0];
  endfunction

  // FIFO drain handshake
  logic                 f_valid;
  logic signed [SW-1:0] f_data;
  logic                 f_ready;

  iisd_fifo #(
    .W (SW),
    .D (DEPTH)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_in_valid  (i_in_valid),
    .i_in_data   (i_in_data),
    .o_in_ready  (o_in_ready),
    .o_out_valid (f_valid),
    .o_out_data  (f_data),
    .i_out_ready (f_ready)
  );

  // Half-band state
  iisd_phase_t          phase;
  iisd_phase_t          next_phase;
  logic signed [SW-1:0] hb_line [HBN];
  logic signed [SW-1:0] next_hb_line [HBN];
  logic                 hb_valid;
  logic                 next_hb_valid;
  logic signed [SW-1:0] hb_out;
  logic signed [SW-1:0] next_hb_out;
  logic                 shift_en;
  logic signed [SW-1:0] shift_in;

  // Pop one sample every cycle in pass-through, every other cycle when doubling
  // two modes
  always_comb
  begin
    f_ready    = 1'b0;
    shift_en   = 1'b0;
    shift_in   = '0;
    next_phase = phase;
    if (!i_interp_x2)
    begin
      f_ready    = 1'b1;
      shift_en   = f_valid;
      shift_in   = f_data;
      next_phase = IISD_PH_IN;
    end
    else
    begin
      case (phase)
        IISD_PH_IN:
        begin
          f_ready  = 1'b1;
          shift_en = f_valid;
          shift_in = f_data;
          if (f_valid)
            next_phase = IISD_PH_ZERO;
        end
        IISD_PH_ZERO:
        begin
          shift_en   = 1'b1;
          shift_in   = '0;
          next_phase = IISD_PH_IN;
        end
        default:
          next_phase = IISD_PH_IN;
      endcase
    end
  end

  // Half-band filter on the zero-stuffed stream; pass-through bypasses the taps
  // symmetric taps
  always_comb
  begin
    logic signed [AW-1:0] acc;
    acc = '0;
    for (int k = 0; k < HBN; k++)
      next_hb_line[k] = hb_line[k];
    if (shift_en)
    begin
      next_hb_line[0] = shift_in;
      for (int k = 1; k < HBN; k++)
        next_hb_line[k] = hb_line[k-1];
    end
    for (int k = 0; k < 14; k++)
      acc = acc + AW'(HB_C[k]) * (AW'(next_hb_line[2*k]) + AW'(next_hb_line[HBN-1-2*k]));
    // Zero stuffing halves the gain, so the centre and side taps are doubled here
    acc = (acc + AW'(`IISD_HB_CENTRE) * AW'(next_hb_line[(HBN-1)/2])) * 2;
    next_hb_valid = shift_en;
    if (!shift_en)
      next_hb_out = hb_out;
    else if (i_interp_x2)
      next_hb_out = rnd_sat(acc, `IISD_HB_SHIFT);
    else
      next_hb_out = shift_in;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      phase    <= IISD_PH_IN;
      hb_valid <= 1'b0;
      hb_out   <= '0;
      for (int k = 0; k < HBN; k++)
        hb_line[k] <= '0;
    end
    else
    begin
      phase    <= next_phase;
      hb_valid <= next_hb_valid;
      hb_out   <= next_hb_out;
      for (int k = 0; k < HBN; k++)
        hb_line[k] <= next_hb_line[k];
    end
  end

  // Inverse sinc state; one register stage of delay, enabled or bypassed
  logic signed [SW-1:0] is_line [7];
  logic signed [SW-1:0] next_is_line [7];
  logic                 is_valid;
  logic                 next_is_valid;
  logic signed [SW-1:0] is_out;
  logic signed [SW-1:0] next_is_out;

  // symmetric taps
  // Net gain 192-26=166 over 256 gives the intrinsic loss
  // insertion loss
  always_comb
  begin
    logic signed [AW-1:0] acc;
    acc = '0;
    for (int k = 0; k < 7; k++)
      next_is_line[k] = is_line[k];
    if (hb_valid)
    begin
      next_is_line[0] = hb_out;
      for (int k = 1; k < 7; k++)
        next_is_line[k] = is_line[k-1];
    end
    acc = AW'(`IISD_IS_C1) * (AW'(next_is_line[0]) + AW'(next_is_line[6]))
        + AW'(`IISD_IS_C2) * (AW'(next_is_line[1]) + AW'(next_is_line[5]))
        + AW'(`IISD_IS_C3) * (AW'(next_is_line[2]) + AW'(next_is_line[4]))
        + AW'(`IISD_IS_C4) * AW'(next_is_line[3]);
    next_is_valid = hb_valid;
    if (!hb_valid)
      next_is_out = is_out;
    else if (i_inverse_sinc_enable)
      next_is_out = rnd_sat(acc, `IISD_IS_SHIFT);
    else
      next_is_out = hb_out;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      is_valid <= 1'b0;
      is_out   <= '0;
      for (int k = 0; k < 7; k++)
        is_line[k] <= '0;
    end
    else
    begin
      is_valid <= next_is_valid;
      is_out   <= next_is_out;
      for (int k = 0; k < 7; k++)
        is_line[k] <= next_is_line[k];
    end
  end

  // Gain and offset; saturation here protects against excess compensating gain
  // stage order
  logic                 next_out_valid;
  logic signed [SW-1:0] next_out_data;

  always_comb
  begin
    logic signed [AW-1:0] acc;
    acc = AW'(is_out) * AW'($signed({1'b0, i_gain}));
    acc = acc + (AW'(i_offset) <<< `IISD_GAIN_SHIFT);
    next_out_valid = is_valid;
    next_out_data  = is_valid ? rnd_sat(acc, `IISD_GAIN_SHIFT) : o_out_data;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_out_valid <= 1'b0;
      o_out_data  <= '0;
    end
    else
    begin
      o_out_valid <= next_out_valid;
      o_out_data  <= next_out_data;
    end
  end
endmodule

// ==== rtl/iisd_defines.svh ====
// Constants of the interpolating inverse sinc datapath.
// Assumes inclusion by bare name from rtl files.
`ifndef IISD_DEFINES_SVH
`define IISD_DEFINES_SVH
`define IISD_SAMPLE_W      16
`define IISD_HB_TAPS       55
`define IISD_HB_CENTRE     32768
`define IISD_HB_SHIFT      16
`define IISD_IS_SHIFT      8
`define IISD_IS_C1         -1
`define IISD_IS_C2         4
`define IISD_IS_C3         -16
`define IISD_IS_C4         192
`define IISD_FIFO_DEPTH    32
`define IISD_GAIN_UNITY    16'h4000
`define IISD_GAIN_SHIFT    14
`endif

// ==== rtl/iisd_pkg.sv ====
// Types of the interpolating inverse sinc datapath.
// Assumes nothing beyond the defines header.
package iisd_pkg;
  typedef enum logic [1:0]
  {
    IISD_PH_IN   = 2'b00,
    IISD_PH_ZERO = 2'b01
  } iisd_phase_t;
endpackage

// ==== rtl/iisd_fifo.sv ====
// Sample FIFO with parameterised width and depth.
// Assumes a single clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module iisd_fifo #(
  parameter int W = 16,
  parameter int D = 32
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  // Fill side
  input  wire logic         i_in_valid,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_in_ready,
  // Drain side
  output logic              o_out_valid,
  output logic [W-1:0]      o_out_data,
  input  wire logic         i_out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0]  wr_ptr;
  logic [AW:0]  rd_ptr;
  logic [AW:0]  next_wr_ptr;
  logic [AW:0]  next_rd_ptr;
  logic         full;
  logic         empty;
  logic         push;
  logic         pop;

  // Full when pointers differ only in the wrap bit
  always_comb
  begin
    full        = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    empty       = (wr_ptr == rd_ptr);
    push        = i_in_valid && !full;
    pop         = i_out_ready && !empty;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    o_in_ready  = !full;
    o_out_valid = !empty;
    o_out_data  = mem[rd_ptr[AW-1:0]];
  end

  // Pointer registers
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // Storage has no reset; only written slots are ever read
  always_ff @(posedge i_clk)
  begin
    if (push)
      mem[wr_ptr[AW-1:0]] <= i_in_data;
  end
endmodule

// ==== test/iisd_datapath_monitor.sv ====
// Port timing checker of the datapath.
// Assumes the iisd_datapath ports and one clock.
`timescale 1ns/1ps
module iisd_mon (
  // Clock and reset
  input wire logic               i_clk,
  input wire logic               i_rst_n,
  // Upstream side
  input wire logic               i_in_valid,
  input wire logic signed [15:0] i_in_data,
  input wire logic               o_in_ready,
  // Configuration
  input wire logic               i_interp_x2,
  input wire logic               i_inverse_sinc_enable,
  input wire logic [15:0]        i_gain,
  input wire logic signed [15:0] i_offset,
  // Converter side
  input wire logic               o_out_valid,
  input wire logic signed [15:0] o_out_data
);
  logic take;
  logic plain;
  // Accepted sample, and the all-bypass unity setting
  assign take  = i_in_valid && o_in_ready;
  assign plain = !i_interp_x2 && !i_inverse_sinc_enable && i_gain == 16'h4000 && i_offset == 16'sh0000;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // Interpolated samples leave as a pair
  sequence pair_s;
    o_out_valid [*2];
  endsequence
  // A full FIFO frees a slot at half rate
  sequence free_s;
    ##[1:2] o_in_ready;
  endsequence
  pass_lat_a: assert property (!i_interp_x2 && take |-> ##4 o_out_valid)
    else $error("pass sample late");
  pass_src_a: assert property (!i_interp_x2 && o_out_valid |-> $past(take, 4))
    else $error("pass sample unexpected");
  x2_pair_a: assert property (i_interp_x2 && $rose(o_out_valid) |-> pair_s)
    else $error("x2 sample unpaired");
  x2_due_a: assert property (i_interp_x2 && take |-> ##[4:72] o_out_valid)
    else $error("x2 sample missing");
  fill_drain_a: assert property (i_interp_x2 && $fell(o_in_ready) |-> free_s)
    else $error("full FIFO stuck");
  pass_ready_a: assert property (!i_interp_x2 && !$past(i_interp_x2, 8) |-> o_in_ready)
    else $error("pass FIFO refused");
  bypass_id_a: assert property (plain && o_out_valid |-> o_out_data == $past(i_in_data, 4))
    else $error("bypass path altered data");
  out_hold_a: assert property (!o_out_valid |-> $stable(o_out_data))
    else $error("output moved while idle");
endmodule
bind iisd_datapath iisd_mon mon_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_in_valid(i_in_valid),
  .i_in_data(i_in_data), .o_in_ready(o_in_ready), .i_interp_x2(i_interp_x2),
  .i_inverse_sinc_enable(i_inverse_sinc_enable), .i_gain(i_gain), .i_offset(i_offset),
  .o_out_valid(o_out_valid), .o_out_data(o_out_data));

// ==== test/iisd_src.sv ====
// Upstream sample source model.
// Assumes its tasks start just after a rising edge.
`timescale 1ns/1ps
module iisd_src (
  // Clock
  input  wire logic          i_clk,
  // Sample handshake
  input  wire logic          i_ready,
  output logic               o_valid,
  output logic signed [15:0] o_data,
  // Refusal outlasted its bound
  output logic               o_stuck
);
  // Quiet lines at start
  initial
  begin
    o_valid = 1'b0;
    o_data  = 16'sh0000;
    o_stuck = 1'b0;
  end
  // Hold sample until an edge sees ready high
  task automatic send(input logic signed [15:0] d);
    o_valid = 1'b1;
    o_data  = d;
    for (int n = 0; n < 100 && !i_ready; n++)
      @(posedge i_clk) #1;
    o_stuck = o_stuck | !i_ready;
    @(posedge i_clk) #1;
  endtask
  // Released data toggles so no stale sample survives
  task automatic idle(input int k);
    o_valid = 1'b0;
    repeat (k)
    begin
      o_data = ~o_data;
      @(posedge i_clk) #1;
    end
  endtask
endmodule

// ==== test/tb_iisd_datapath.sv ====
// Self-checking bench of the datapath.
// Assumes the source model and the bound checker.
`timescale 1ns/1ps
module tb_iisd_datapath;
  logic               clk = 1'b0;
  logic               rst_n = 1'b0;
  logic               vld;
  logic signed [15:0] dat;
  logic               rdy;
  logic               stuck;
  logic               x2 = 1'b0;
  logic               isinc = 1'b0;
  logic [15:0]        gain = 16'h4000;
  logic signed [15:0] offs = 16'sh0000;
  logic               ovld;
  logic signed [15:0] odat;
  logic               full_seen = 1'b0;
  logic signed [15:0] s;
  logic signed [15:0] got [$];
  logic signed [15:0] exp_q [$];
  logic [31:0]        cfg [4] = '{32'h40000000, 32'h40007000, 32'h80000000, 32'h2000FF00};
  int                 tap [11] = '{0, 0, -10, 40, -160, 1920, -160, 40, -10, 0, 0};
  int                 err_total = 0;
  int                 compares = 0;
  int                 n;
  // Sample clock, 4 ns
  always #2 clk = ~clk;
  iisd_datapath dut_u (.i_clk(clk), .i_rst_n(rst_n), .i_in_valid(vld), .i_in_data(dat),
    .o_in_ready(rdy), .i_interp_x2(x2), .i_inverse_sinc_enable(isinc), .i_gain(gain), .i_offset(offs),
    .o_out_valid(ovld), .o_out_data(odat));
  iisd_src src_u (.i_clk(clk), .i_ready(rdy), .o_valid(vld), .o_data(dat), .o_stuck(stuck));
  // Record samples and any refusal
  always @(posedge clk)
  begin
    if (ovld === 1'b1)
      got.push_back(odat);
    if (rdy === 1'b0)
      full_seen <= 1'b1;
  end
  task automatic chk(input logic signed [15:0] a, input logic signed [15:0] e);
    compares++;
    if (a !== e)
    begin
      err_total++;
      $display("ERROR t=%0t got %h exp %h", $time, a, e);
    end
  endtask
  // Clip instead of wrapping
  function automatic logic signed [15:0] sat(input longint v);
    return (v > 32767) ? 16'sh7FFF : (v < -32768) ? 16'sh8000 : 16'(v);
  endfunction
  // Gain rounds half up before offset
  function automatic logic signed [15:0] gain_off(input logic signed [15:0] x);
    return sat(longint'(sat((longint'(x) * longint'(gain) + 8192) >>> 14)) + longint'(offs));
  endfunction
  // Let the pipeline empty, then compare in order
  task automatic settle_cmp();
    repeat (12) @(posedge clk);
    #1;
    chk(16'(got.size()), 16'(exp_q.size()));
    foreach (exp_q[i])
      chk(got[i], exp_q[i]);
    got.delete();
    exp_q.delete();
  endtask
  task automatic do_reset();
    rst_n = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk({14'h0000, ovld, rdy}, 16'h0001);
    chk(odat, 16'sh0000);
    rst_n = 1'b1;
    got.delete();
  endtask
  task automatic close_out();
    if (err_total == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    void'($urandom(32'h9B7068A0));
    do_reset();
    foreach (cfg[c])
    begin
      {gain, offs} = cfg[c];
      for (n = 0; n < 26; n++)
      begin
        s = (n == 0) ? 16'sh7FFF : (n == 1) ? 16'sh8000 : 16'($urandom());
        exp_q.push_back(gain_off(s));
        src_u.send(s);
        if ($urandom_range(1) == 1)
          src_u.idle(1);
      end
      src_u.idle(1);
      settle_cmp();
    end
    {gain, offs} = 32'h40000000;
    isinc = 1'b1;
    for (n = 0; n < 17; n++)
      src_u.send((n == 8) ? 16'sh0A00 : 16'sh0000);
    src_u.idle(1);
    repeat (12) @(posedge clk);
    #1;
    chk(16'(got.size()), 16'h0011);
    for (n = 0; n < 11; n++)
      chk(got[n + 6], 16'(tap[n]));
    got.delete();
    isinc = 1'b0;
    x2 = 1'b1;
    repeat (80)
      src_u.send(16'sh03E8);
    src_u.idle(1);
    for (n = 0; n < 250 && got.size() < 160; n++)
      @(posedge clk);
    #1;
    chk(16'(got.size()), 16'h00A0);
    chk({15'h0000, full_seen}, 16'h0001);
    chk({15'h0000, rdy}, 16'h0001);
    for (n = 60; n < 160; n++)
      chk(16'(got[n] > 16'sh03E6 && got[n] < 16'sh03EA), 16'h0001);
    chk({15'h0000, stuck}, 16'h0000);
    x2 = 1'b0;
    do_reset();
    close_out();
  end
endmodule
